// *** bsc_core.sv ***
/*
 * Execution core for the bit-test skips, subroutine call, accumulator and
 * register clear and watchdog clear, with a one-word prefetch, 32 file
 * registers and an AHB-Lite register window for software.
 * Assumes fetch_word is the program word at program_counter, valid in the
 * same cycle, and that one clock is one instruction cycle.
 */
`default_nettype none

module bsc_core #(
	parameter logic [10:0] RESET_ADDR = bsc_pkg::RESET_VECTOR,
	parameter int STACK_DEPTH = 2,
	parameter int PRESCALE_BITS = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [10:0] program_counter,
	input wire logic [11:0] fetch_word,
	output logic watchdog_timeout
);

	initial begin
		if (PRESCALE_BITS < 1 || PRESCALE_BITS > 16) begin
			$error("prescaler width must lie in 1..16");
		end
		if (STACK_DEPTH < 1) begin
			$error("return stack needs at least one entry");
		end
	end

	// ==========================================================
	// decoding helpers
	function automatic bsc_pkg::bsc_op_type decode_op(input logic [11:0] word);
		if (word[11:8] == bsc_pkg::SKIP_CLR_NIBBLE) begin
			return bsc_pkg::OP_SKIP_CLR; // RULE_14
		end else if (word[11:8] == bsc_pkg::SKIP_SET_NIBBLE) begin
			return bsc_pkg::OP_SKIP_SET; // RULE_15
		end else if (word[11:8] == bsc_pkg::CALL_NIBBLE) begin
			return bsc_pkg::OP_CALL;
		end else if (word == bsc_pkg::CLR_ACC_WORD) begin
			return bsc_pkg::OP_CLR_ACC;
		end else if (word[11:5] == bsc_pkg::CLR_REG_TOP) begin
			return bsc_pkg::OP_CLR_REG;
		end else if (word == bsc_pkg::WDT_CLEAR_WORD) begin
			return bsc_pkg::OP_WDT_CLR;
		end
		return bsc_pkg::OP_IDLE;
	endfunction : decode_op

	function automatic logic window_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : window_hit

	// ==========================================================
	// state
	logic [11:0] exec_word;
	logic [7:0] acc;
	logic [7:0] status;
	logic [1:0] ctrl;
	logic [7:0] file_mem [32];
	logic dp_wr;
	logic [7:0] dp_addr;
	logic [10:0] stack_top;
	logic [7:0] watchdog_counter;
	logic [PRESCALE_BITS-1:0] prescaler;

	bsc_pkg::bsc_op_type op;
	logic run;
	logic [4:0] reg_addr;
	logic [2:0] bit_pos;
	logic tested_bit;
	logic skip_taken;
	logic flush;
	logic wdt_clear;
	logic bus_wr;
	logic [31:0] next_rdata;
	logic [10:0] next_pc;

	// ==========================================================
	// operand extraction and skip decision
	assign run = ctrl[0];
	assign op = decode_op(exec_word);
	assign reg_addr = exec_word[bsc_pkg::REG_ADDR_LSB +: 5]; // RULE_04
	assign bit_pos = exec_word[bsc_pkg::BIT_POS_LSB +: 3]; // RULE_04
	assign tested_bit = file_mem[reg_addr][bit_pos];
	assign skip_taken = (op == bsc_pkg::OP_SKIP_CLR && !tested_bit) // RULE_01
		|| (op == bsc_pkg::OP_SKIP_SET && tested_bit); // RULE_03
	// a call also discards the prefetch, which gives it its second cycle
	assign flush = skip_taken || op == bsc_pkg::OP_CALL; // RULE_02 RULE_09
	assign wdt_clear = run && op == bsc_pkg::OP_WDT_CLR;
	assign bus_wr = dp_wr;

	// ==========================================================
	// bus slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// data-phase capture; htrans[1] covers NONSEQ and SEQ
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
		end else if (hready) begin
			dp_wr <= hsel && htrans[1] && hwrite && haddr[31:8] == 24'h000000;
			dp_addr <= haddr[7:0];
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		next_rdata = 32'h00000000;
		if (haddr[31:8] != 24'h000000) begin
			next_rdata = 32'h00000000;
		end else if (haddr[7] == 1'b1) begin
			next_rdata = {24'h000000, file_mem[haddr[6:2]]};
		end else if (window_hit(haddr[7:0], bsc_pkg::CTRL_OFS)) begin
			next_rdata = {30'h00000000, ctrl};
		end else if (window_hit(haddr[7:0], bsc_pkg::STATUS_OFS)) begin
			next_rdata = {24'h000000, status};
		end else if (window_hit(haddr[7:0], bsc_pkg::ACC_OFS)) begin
			next_rdata = {24'h000000, acc};
		end else if (window_hit(haddr[7:0], bsc_pkg::PC_OFS)) begin
			next_rdata = {21'h000000, program_counter};
		end else if (window_hit(haddr[7:0], bsc_pkg::WDOG_OFS)) begin
			next_rdata = {8'h00, 16'(prescaler), watchdog_counter};
		end else if (window_hit(haddr[7:0], bsc_pkg::STACK_OFS)) begin
			next_rdata = {21'h000000, stack_top};
		end
	end

	// read data is sampled at the address phase so it stands through the data phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// ==========================================================
	// control register: run enable and prescaler assignment
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= bsc_pkg::CTRL_RESET;
		end else if (bus_wr && window_hit(dp_addr, bsc_pkg::CTRL_OFS)) begin
			ctrl <= hwdata[1:0];
		end
	end

	// ==========================================================
	// fetch and program counter; a bus write to the counter flushes the prefetch
	always_comb begin
		next_pc = program_counter + 11'h001;
		if (op == bsc_pkg::OP_CALL) begin
			next_pc = {status[bsc_pkg::PAGE_LSB +: 2], 1'b0, exec_word[7:0]}; // RULE_07 RULE_08
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			program_counter <= RESET_ADDR;
			exec_word <= bsc_pkg::IDLE_WORD;
		end else if (bus_wr && window_hit(dp_addr, bsc_pkg::PC_OFS)) begin
			program_counter <= hwdata[10:0];
			exec_word <= bsc_pkg::IDLE_WORD;
		end else if (run) begin
			program_counter <= next_pc;
			exec_word <= flush ? bsc_pkg::IDLE_WORD : fetch_word; // RULE_02 RULE_16
		end
	end

	// ==========================================================
	// accumulator; the core's clear lands after a same-cycle bus write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc <= 8'h00;
		end else if (run && op == bsc_pkg::OP_CLR_ACC) begin
			acc <= 8'h00; // RULE_05
		end else if (bus_wr && window_hit(dp_addr, bsc_pkg::ACC_OFS)) begin
			acc <= hwdata[7:0];
		end
	end

	// ==========================================================
	// status: zero flag, active-low expired and sleep bits, page bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status <= bsc_pkg::STATUS_RESET;
		end else begin
			if (bus_wr && window_hit(dp_addr, bsc_pkg::STATUS_OFS)) begin
				status <= hwdata[7:0];
			end
			if (run && (op == bsc_pkg::OP_CLR_ACC || op == bsc_pkg::OP_CLR_REG)) begin
				status[bsc_pkg::ZERO_BIT] <= 1'b1; // RULE_05 RULE_13
			end
			if (watchdog_timeout) begin
				status[bsc_pkg::EXPIRED_BIT] <= 1'b0;
			end
			if (wdt_clear) begin
				status[bsc_pkg::EXPIRED_BIT] <= 1'b1; // RULE_12
				status[bsc_pkg::SLEEP_BIT] <= 1'b1; // RULE_12
			end
		end
	end

	// ==========================================================
	// file registers; no reset, so software or code must initialise them
	always_ff @(posedge clk) begin
		if (bus_wr && dp_addr[7]) begin
			file_mem[dp_addr[6:2]] <= hwdata[7:0];
		end
		if (run && op == bsc_pkg::OP_CLR_REG) begin
			file_mem[reg_addr] <= 8'h00; // RULE_13
		end
	end

	// ==========================================================
	// return stack and watchdog
	bsc_return_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(11)
	) u_stack (
		.clk(clk),
		.rst_n(rst_n),
		.push(run && op == bsc_pkg::OP_CALL), // RULE_06
		.push_data(program_counter), // RULE_06
		.top(stack_top)
	);

	bsc_watchdog #(
		.PRESCALE_BITS(PRESCALE_BITS)
	) u_watchdog (
		.clk(clk),
		.rst_n(rst_n),
		.clear_op(wdt_clear),
		.prescale_to_watchdog(ctrl[1]),
		.watchdog_counter(watchdog_counter),
		.prescaler(prescaler),
		.timeout(watchdog_timeout)
	);

	// ==========================================================
	// assertions: all but prescale_clear_a, status_set_a and prescale_keep_a guarded against a bus write landing in the same cycle
	logic quiet;
	assign quiet = run && !bus_wr;

	skip_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		quiet && op == bsc_pkg::OP_SKIP_CLR && !tested_bit |=> exec_word == bsc_pkg::IDLE_WORD)
		else $error("skip-if-clear did not discard the prefetch");

	no_skip_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
		quiet && op == bsc_pkg::OP_SKIP_CLR && tested_bit |=> exec_word == $past(fetch_word))
		else $error("skip-if-clear discarded a word with the bit set");

	skip_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
		quiet && op == bsc_pkg::OP_SKIP_SET |=> (exec_word == bsc_pkg::IDLE_WORD) == $past(tested_bit)
			|| $past(fetch_word) == bsc_pkg::IDLE_WORD)
		else $error("skip-if-set outcome wrong");

	clear_acc_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
		quiet && op == bsc_pkg::OP_CLR_ACC |=> acc == 8'h00 && status[bsc_pkg::ZERO_BIT])
		else $error("accumulator clear failed");

	call_push_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		quiet && op == bsc_pkg::OP_CALL |=> stack_top == $past(program_counter))
		else $error("call pushed the wrong return address");

	call_target_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
		quiet && op == bsc_pkg::OP_CALL |=> program_counter == {$past(status[6:5]), 1'b0, $past(exec_word[7:0])})
		else $error("call target wrong");

	call_cycles_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
		quiet && op == bsc_pkg::OP_CALL ##1 quiet |-> op == bsc_pkg::OP_IDLE ##1 exec_word == $past(fetch_word))
		else $error("call did not take two cycles");

	wdt_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
		quiet && op == bsc_pkg::OP_WDT_CLR |=> watchdog_counter == 8'h00 && status[4:3] == 2'b11)
		else $error("watchdog clear incomplete");

	prescale_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
		wdt_clear |=> (prescaler == '0) || !$past(ctrl[1]))
		else $error("prescaler not cleared");

	clear_reg_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
		quiet && op == bsc_pkg::OP_CLR_REG |=> file_mem[$past(reg_addr)] == 8'h00 && status[bsc_pkg::ZERO_BIT])
		else $error("register clear failed");

	idle_slot_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
		quiet && exec_word == bsc_pkg::IDLE_WORD && !watchdog_timeout
			|=> $stable(acc) && $stable(status) && $stable(stack_top)
			&& program_counter == $past(program_counter) + 11'h001)
		else $error("idle slot changed state");

	// fetch side: a taken skip flushes one slot and leaves data state alone
	skip_flush_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
		quiet && skip_taken |=> op == bsc_pkg::OP_IDLE && program_counter == $past(program_counter) + 11'h001)
		else $error("taken skip did not substitute an idle slot");

	skip_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
		quiet && !watchdog_timeout && (op == bsc_pkg::OP_SKIP_CLR || op == bsc_pkg::OP_SKIP_SET)
			|=> $stable(acc) && $stable(status) && $stable(stack_top))
		else $error("bit test changed data state");

	// call and clear side effects
	call_literal_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
		quiet && op == bsc_pkg::OP_CALL |=> program_counter[7:0] == $past(exec_word[7:0]))
		else $error("call literal not loaded");

	stack_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
		quiet && op != bsc_pkg::OP_CALL |=> $stable(stack_top))
		else $error("stack moved without a call");

	clear_reg_acc_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_13
		quiet && op == bsc_pkg::OP_CLR_REG |=> $stable(acc))
		else $error("register clear touched the accumulator");

	// watchdog clear wins over a bus write or timeout in the same cycle
	status_set_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
		wdt_clear |=> status[bsc_pkg::EXPIRED_BIT] && status[bsc_pkg::SLEEP_BIT])
		else $error("watchdog clear left a status bit low");

	prescale_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
		wdt_clear && !ctrl[1] |=> $stable(prescaler))
		else $error("timer prescaler disturbed by watchdog clear");

	skip_seen_c: cover property (@(posedge clk) disable iff (!rst_n) quiet && skip_taken);
	call_seen_c: cover property (@(posedge clk) disable iff (!rst_n) quiet && op == bsc_pkg::OP_CALL);
	wdt_seen_c: cover property (@(posedge clk) disable iff (!rst_n) wdt_clear && ctrl[1]);
	timeout_seen_c: cover property (@(posedge clk) disable iff (!rst_n) watchdog_timeout);
	clr_reg_seen_c: cover property (@(posedge clk) disable iff (!rst_n) quiet && op == bsc_pkg::OP_CLR_REG);

endmodule : bsc_core

`default_nettype wire

// *** bsc_pkg.sv ***
/*
 * Shared constants for the bit-test/skip, call and clear execution block:
 * opcode patterns, operand field positions, status bit positions, reset
 * values and the register window offsets seen over the AHB-Lite slave.
 * Assumes a 12-bit instruction word and an 11-bit program address.
 */
// Function
// (RULE_01) skip-if-clear skips the next instruction when the tested bit is zero
// (RULE_02) a taken skip replaces the prefetched word by an idle slot
// (RULE_03) skip-if-set skips the next instruction when the tested bit is one
// (RULE_04) bit tests take a register 0 to 31 and a bit 0 to 7
// (RULE_05) clearing the accumulator writes zero to it and sets the zero flag
// (RULE_06) a call pushes the address after the call onto the return stack
// (RULE_07) a call loads its eight-bit literal into program counter bits 7:0
// (RULE_08) a call loads counter bits 10:9 from status 6:5 and clears bit 8
// (RULE_09) a call occupies two instruction cycles
// (RULE_10) watchdog clear resets the watchdog counter to zero
// (RULE_11) watchdog clear zeroes the prescaler only when it serves the watchdog
// (RULE_12) watchdog clear sets both active-low expired and sleep status bits
// (RULE_13) clearing a register writes zero to it and sets the zero flag
// (RULE_14) skip-if-clear decodes from top nibble 0110, bit field, register field
// (RULE_15) skip-if-set decodes from top nibble 0111, bit field, register field
// (RULE_16) the substituted idle slot changes nothing except the program counter
`default_nettype none

package bsc_pkg;

	// ==========================================================
	// instruction encodings
	localparam logic [3:0] SKIP_CLR_NIBBLE = 4'h6;
	localparam logic [3:0] SKIP_SET_NIBBLE = 4'h7;
	localparam logic [3:0] CALL_NIBBLE = 4'h9;
	localparam logic [11:0] IDLE_WORD = 12'h000;
	localparam logic [11:0] WDT_CLEAR_WORD = 12'h004;
	localparam logic [11:0] CLR_ACC_WORD = 12'h040;
	localparam logic [6:0] CLR_REG_TOP = 7'h03;

	// ==========================================================
	// operand fields and status bits
	localparam int BIT_POS_LSB = 5;
	localparam int REG_ADDR_LSB = 0;
	localparam int ZERO_BIT = 2;
	localparam int SLEEP_BIT = 3;
	localparam int EXPIRED_BIT = 4;
	localparam int PAGE_LSB = 5;

	// ==========================================================
	// reset values
	localparam logic [10:0] RESET_VECTOR = 11'h000;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// ==========================================================
	// register window byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] ACC_OFS = 8'h08;
	localparam logic [7:0] PC_OFS = 8'h0C;
	localparam logic [7:0] WDOG_OFS = 8'h10;
	localparam logic [7:0] STACK_OFS = 8'h14;
	localparam logic [7:0] FILE_BASE = 8'h80;

	typedef enum {
		OP_IDLE,
		OP_SKIP_CLR,
		OP_SKIP_SET,
		OP_CLR_ACC,
		OP_CLR_REG,
		OP_CALL,
		OP_WDT_CLR
	} bsc_op_type;

endpackage : bsc_pkg

`default_nettype wire

// *** bsc_return_stack.sv ***
/*
 * Hardware return stack, push only: a new entry shifts the older ones down.
 * Assumes pops are handled by return logic that is not part of this block.
 */
`default_nettype none

module bsc_return_stack #(
	parameter int DEPTH = 2,
	parameter int WIDTH = 11
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [WIDTH-1:0] push_data,
	output logic [WIDTH-1:0] top
);

	initial begin
		if (DEPTH < 1 || WIDTH < 1) begin
			$error("stack needs depth and width of at least one");
		end
	end

	logic [WIDTH-1:0] entry [DEPTH];

	// ==========================================================
	// shift on push; the oldest entry falls off the bottom silently
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				entry[i] <= '0;
			end
		end else if (push) begin
			entry[0] <= push_data;
			for (int i = 1; i < DEPTH; i++) begin
				entry[i] <= entry[i-1];
			end
		end
	end

	assign top = entry[0];

endmodule : bsc_return_stack

`default_nettype wire

// *** bsc_watchdog.sv ***
/*
 * Watchdog counter with its shared prescaler. Assumes one tick per clock;
 * when the prescaler belongs to the timer it is left alone and the counter
 * advances every clock.
 */
`default_nettype none

module bsc_watchdog #(
	parameter int PRESCALE_BITS = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear_op,
	input wire logic prescale_to_watchdog,
	output logic [7:0] watchdog_counter,
	output logic [PRESCALE_BITS-1:0] prescaler,
	output logic timeout
);

	initial begin
		if (PRESCALE_BITS < 1) begin
			$error("prescaler needs at least one bit");
		end
	end

	logic tick;

	// the counter steps on prescaler wrap only while the prescaler is ours
	assign tick = !prescale_to_watchdog || (&prescaler);

	// ==========================================================
	// prescaler: cleared by the clear op only when assigned here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prescaler <= '0;
		end else if (prescale_to_watchdog) begin
			if (clear_op) begin
				prescaler <= '0; // RULE_11
			end else begin
				prescaler <= prescaler + PRESCALE_BITS'(1);
			end
		end
	end

	// ==========================================================
	// counter and timeout pulse; clear beats an overflow in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_counter <= 8'h00;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (clear_op) begin
				watchdog_counter <= 8'h00; // RULE_10
			end else if (tick) begin
				watchdog_counter <= watchdog_counter + 8'h01;
				timeout <= &watchdog_counter;
			end
		end
	end

endmodule : bsc_watchdog

`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench for the bit-test skip, call and clear execution core.
 * Assumes bsc_pkg and bsc_core are compiled first, the program memory is a
 * plain array read combinationally at program_counter, and the bench is the
 * only AHB-Lite master on the register window.
 */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// signals and design
	localparam int TIMEOUT_CYCLES = 5000;
	localparam logic [31:0] A_CTRL = {24'h0, bsc_pkg::CTRL_OFS};
	localparam logic [31:0] A_STAT = {24'h0, bsc_pkg::STATUS_OFS};
	localparam logic [31:0] A_ACC = {24'h0, bsc_pkg::ACC_OFS};
	localparam logic [31:0] A_PC = {24'h0, bsc_pkg::PC_OFS};
	localparam logic [31:0] A_WDOG = {24'h0, bsc_pkg::WDOG_OFS};
	localparam logic [31:0] A_STACK = {24'h0, bsc_pkg::STACK_OFS};
	logic clk;
	logic rst_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hready;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic [10:0] program_counter;
	logic [11:0] fetch_word;
	logic [11:0] rom [0:2047];
	logic [31:0] rd;
	logic [7:0] pre_before;
	logic wd_timeout;
	int tmo_pulses = 0;
	int pulses_before = 0;
	int checks = 0;
	int bad_count = 0;
	int cycles = 0;

	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	// combinational program memory, as the core expects
	assign fetch_word = rom[program_counter];

	bsc_core u_dut (
		.clk(clk),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.program_counter(program_counter),
		.fetch_word(fetch_word),
		.watchdog_timeout(wd_timeout)
	);

	// ==========================================================
	// clock and hang guard
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	// a stuck handshake would otherwise wait forever
	always @(posedge clk) begin
		cycles++;
		if (cycles == TIMEOUT_CYCLES) begin
			bad_count++;
			$display("CHECK FAILED at %0t: run timed out", $time);
			complete_run();
		end
	end

	// timeout pulses last one cycle, so count them mid-cycle
	always @(negedge clk) begin
		if (wd_timeout === 1'b1) begin
			tmo_pulses++;
		end
	end

	// ==========================================================
	// shared tasks
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// address phase held until ready, then data phase held until ready
	task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= data;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
	endtask : bus_write

	task automatic bus_read(input logic [31:0] addr, output logic [31:0] data);
		hsel <= 1'b1;
		haddr <= addr;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		data = hrdata;
	endtask : bus_read

	task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp, input string what);
		bus_read(addr, rd);
		check(rd, exp, what);
		check({31'h0, hresp}, 32'h0, "response not okay");
	endtask : rd_chk

	function automatic logic [31:0] freg(input int idx);
		return {24'h0, bsc_pkg::FILE_BASE} + 32'(idx * 4);
	endfunction : freg

	// loading the counter flushes the prefetch, so each program starts clean
	task automatic run_prog(input logic [10:0] start, input logic [1:0] mode);
		bus_write(A_PC, {21'h0, start});
		bus_write(A_CTRL, {30'h0, mode} | 32'h1);
		repeat (16) @(posedge clk);
		bus_write(A_CTRL, {30'h0, mode});
	endtask : run_prog

	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		for (int i = 0; i < 2048; i++) rom[i] = bsc_pkg::IDLE_WORD;
		// programs sit far apart so trailing idles never reach another one
		rom[0] = {bsc_pkg::SKIP_CLR_NIBBLE, 3'h7, 5'h1F};
		rom[1] = {bsc_pkg::CLR_REG_TOP, 5'h0A};
		rom[2] = {bsc_pkg::SKIP_CLR_NIBBLE, 3'h1, 5'h00};
		rom[3] = {bsc_pkg::CLR_REG_TOP, 5'h0B};
		rom[4] = {bsc_pkg::SKIP_SET_NIBBLE, 3'h0, 5'h00};
		rom[5] = {bsc_pkg::CLR_REG_TOP, 5'h0C};
		rom[6] = {bsc_pkg::SKIP_SET_NIBBLE, 3'h6, 5'h1F};
		rom[7] = {bsc_pkg::CLR_REG_TOP, 5'h0D};
		rom[11'h080] = bsc_pkg::CLR_ACC_WORD;
		rom[11'h0C0] = bsc_pkg::WDT_CLEAR_WORD;
		rom[11'h1F0] = {bsc_pkg::CALL_NIBBLE, 8'hAB};
		rom[11'h1F1] = {bsc_pkg::CLR_REG_TOP, 5'h0F};
		rom[11'h4AB] = {bsc_pkg::CLR_REG_TOP, 5'h0E};
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);

		// reset values and an address outside the window
		rd_chk(A_CTRL, 32'h0, "ctrl reset");
		rd_chk(A_STAT, 32'h18, "status reset");
		rd_chk(A_ACC, 32'h0, "acc reset");
		rd_chk(A_PC, 32'h0, "pc reset");
		bus_write(32'h100, 32'hFF);
		rd_chk(32'h100, 32'h0, "unmapped read");
		rd_chk(A_CTRL, 32'h0, "ctrl after unmapped write");
		$display("test reset_and_map done");

		// skips on both senses at the operand boundaries
		bus_write(freg(0), 32'h01);
		bus_write(freg(31), 32'h80);
		for (int i = 10; i < 14; i++) bus_write(freg(i), 32'hA5);
		bus_write(A_ACC, 32'h5A);
		run_prog(11'h000, 2'h0);
		rd_chk(freg(10), 32'h0, "clear skip not taken");
		rd_chk(freg(11), 32'hA5, "clear skip taken");
		rd_chk(freg(12), 32'hA5, "set skip taken");
		rd_chk(freg(13), 32'h0, "set skip not taken");
		rd_chk(freg(0), 32'h01, "tested reg 0");
		rd_chk(freg(31), 32'h80, "tested reg 31");
		rd_chk(A_ACC, 32'h5A, "acc after skips");
		rd_chk(A_STACK, 32'h0, "stack after skips");
		bus_read(A_STAT, rd);
		check({31'h0, rd[2]}, 32'h1, "zero after reg clear");
		$display("test skips done");

		// accumulator clear from a cleared zero flag
		bus_write(A_STAT, 32'h18);
		run_prog(11'h080, 2'h0);
		rd_chk(A_ACC, 32'h0, "acc cleared");
		bus_read(A_STAT, rd);
		check({31'h0, rd[2]}, 32'h1, "zero after acc clear");
		$display("test clear_acc done");

		// call from a counter with bit 8 set, page 2
		bus_write(freg(14), 32'h3C);
		bus_write(freg(15), 32'h3C);
		bus_write(A_STAT, 32'h58);
		run_prog(11'h1F0, 2'h0);
		rd_chk(A_STACK, 32'h1F1, "return address");
		rd_chk(freg(14), 32'h0, "target executed");
		rd_chk(freg(15), 32'h3C, "word after call");
		bus_read(A_PC, rd);
		check({29'h0, rd[10:8]}, 32'h4, "pc page bits");
		$display("test call done");

		// watchdog clear with the prescaler parked on the timer at a nonzero count
		bus_write(A_CTRL, 32'h2);
		repeat (40) @(posedge clk);
		bus_write(A_CTRL, 32'h0);
		bus_write(A_STAT, 32'h0);
		bus_read(A_WDOG, rd);
		pre_before = rd[15:8];
		check({31'h0, pre_before != 8'h00}, 32'h1, "prescaler advanced");
		run_prog(11'h0C0, 2'h0);
		bus_read(A_WDOG, rd);
		// cleared at the second run edge, then one tick per clock up to the read
		check({24'h0, rd[7:0]}, 32'h10, "counter restarted");
		check({24'h0, rd[15:8]}, {24'h0, pre_before}, "timer prescaler kept");
		bus_read(A_STAT, rd);
		check({30'h0, rd[4:3]}, 32'h3, "status bits set");

		// and with the prescaler on the watchdog, after it has advanced
		bus_write(A_CTRL, 32'h2);
		repeat (300) @(posedge clk);
		bus_write(A_STAT, 32'h0);
		run_prog(11'h0C0, 2'h2);
		bus_read(A_WDOG, rd);
		check({24'h0, rd[7:0]}, 32'h0, "counter zero");
		check({24'h0, rd[15:8]}, 32'h10, "prescaler restarted");
		bus_read(A_STAT, rd);
		check({30'h0, rd[4:3]}, 32'h3, "status bits set again");
		$display("test watchdog done");

		// a full count in timer mode wraps once, pulses timeout and clears expired_n
		bus_write(A_CTRL, 32'h0);
		bus_write(A_STAT, 32'h18);
		pulses_before = tmo_pulses;
		repeat (260) @(posedge clk);
		bus_read(A_STAT, rd);
		check({31'h0, rd[4]}, 32'h0, "expired cleared by timeout");
		check(32'(tmo_pulses - pulses_before), 32'h1, "one timeout pulse");
		$display("test timeout done");
		complete_run();
	end

endmodule : tb

`default_nettype wire
